// [bhl_irq_regs.sv]
// Buck high-side limit and voltage-scaling interrupt registers with the interrupt pin.
//
// What this block does
// (R1) Unmasked set status bit pulls interrupt low.
// (R2) Masked status bit still records, pin stays.
// (R3) High-side mask bits 0-2, reset masked.
// (R4) High-side sense bits held per switching cycle.
// (R5) Scaling-done flag sets when transition finishes.
// (R6) Scaling-done flag clears on read or W1C.
// (R7) Scaling-done mask bits 0-1, reset masked.
// (R8) Progress bits show transitions under way.
// (R9) High-side status below mask, read/W1C clear.
// (R10) Pin is OR of unmasked; unused bits zero.
// (R11) High-side flag sets on sense rise.
`timescale 1ns/1ps
module bhl_irq_regs #(
  parameter int HS_COUNT   = bhl_pkg::BHL_HS_COUNT,
  parameter int VS_COUNT   = bhl_pkg::BHL_VS_COUNT,
  parameter int PERIOD_CYC = bhl_pkg::BHL_SW_PERIOD_CYC
) (
  input  wire logic                  mclk,           // System clock, 10 MHz.
  input  wire logic                  nrst,           // Asynchronous reset, active low.
  input  wire bhl_pkg::bhl_avs_req_t avsReq,         // Avalon-MM request from the master.
  output logic [31:0]                avsReadData,    // Avalon-MM read data.
  output logic                       avsWaitRequest, // Avalon-MM wait request.
  input  wire logic [HS_COUNT-1:0]   hilimFaultRaw,  // High-side limit comparators.
  input  wire logic [VS_COUNT-1:0]   vscaleBusyRaw,  // Voltage transition in progress.
  output logic                       irqOutN         // Interrupt pin, active low.
);
  import bhl_pkg::*;

  // Refuse counts that do not fit the eight-bit registers.
  if (HS_COUNT < 1 || HS_COUNT > 8 || VS_COUNT < 1 || VS_COUNT > 8) begin : g_chk
    $error("bhl_irq_regs: converter count out of range.");
  end

  // Bus handshake and answer registers.
  bhl_bus_state_t busState_q;
  logic           waitReq_q;
  logic [31:0]    readData_q;
  logic [31:0]    readNext;
  logic           captureRd;

  // Interrupt sources, masks and pin.
  logic [HS_COUNT-1:0] hsSense;
  logic [HS_COUNT-1:0] hsRise;
  logic [HS_COUNT-1:0] hsFlag_q;
  logic [HS_COUNT-1:0] hsFlag_d;
  logic [HS_COUNT-1:0] hsClr;
  logic [HS_COUNT-1:0] hsMask_q;
  logic [VS_COUNT-1:0] vsSync1_q;
  logic [VS_COUNT-1:0] vsSync2_q;
  logic [VS_COUNT-1:0] vsLast_q;
  logic [VS_COUNT-1:0] vsFinish;
  logic [VS_COUNT-1:0] vsDone_q;
  logic [VS_COUNT-1:0] vsDone_d;
  logic [VS_COUNT-1:0] vsClr;
  logic [VS_COUNT-1:0] vsMask_q;
  logic                irqN_q;
  logic                pending;

  // Accepted accesses; a write touches only byte lane 0, where the 8-bit data sits.
  logic       acceptRd;
  logic       acceptWr;
  logic [7:0] wrByte;

  assign captureRd      = (busState_q == BHL_BUS_IDLE) && avsReq.read;
  assign acceptRd       = (busState_q == BHL_BUS_ACK) && avsReq.read;
  assign acceptWr       = (busState_q == BHL_BUS_ACK) && avsReq.write && avsReq.byteenable[0];
  assign wrByte         = avsReq.writedata[7:0];
  assign avsReadData    = readData_q;
  assign avsWaitRequest = waitReq_q;
  assign irqOutN        = irqN_q;

  // Sense conditioning for the high-side limit comparators lives in its own module.
  bhl_sense_hold #(
    .WIDTH      (HS_COUNT),
    .PERIOD_CYC (PERIOD_CYC)
  ) u_sense_hold (
    .mclk      (mclk),
    .nrst      (nrst),
    .faultRaw  (hilimFaultRaw),
    .sense     (hsSense),
    .senseRise (hsRise)
  );

  // Bus handshake: wait request stays high until the slave has the answer ready,
  // then drops for exactly one cycle; that edge is where writes and clears act.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busState_q <= BHL_BUS_IDLE;
      waitReq_q  <= 1'b1;
    end else begin
      case (busState_q)
        BHL_BUS_IDLE: begin
          if (avsReq.read || avsReq.write) begin
            busState_q <= BHL_BUS_ACK;
            waitReq_q  <= 1'b0;
          end
        end
        BHL_BUS_ACK: begin
          busState_q <= BHL_BUS_IDLE;
          waitReq_q  <= 1'b1;
        end
        default: begin
          busState_q <= BHL_BUS_IDLE;
          waitReq_q  <= 1'b1;
        end
      endcase
    end
  end

  // Read mux; unused upper bits and unmapped addresses read as zero.
  // Progress bits are read after their synchroniser, two cycles behind the pins.
  always_comb begin
    readNext = {24'h000000, BHL_READ_ZERO};                             // see (R10)
    if (bhl_hit(avsReq.address, BHL_IDX_HS_STATUS)) begin
      readNext[BHL_FIELD_LSB +: HS_COUNT] = hsFlag_q;                   // see (R9)
    end else if (bhl_hit(avsReq.address, BHL_IDX_HS_MASK)) begin
      readNext[BHL_FIELD_LSB +: HS_COUNT] = hsMask_q;                   // see (R3)
    end else if (bhl_hit(avsReq.address, BHL_IDX_HS_SENSE)) begin
      readNext[BHL_FIELD_LSB +: HS_COUNT] = hsSense;                    // see (R4)
    end else if (bhl_hit(avsReq.address, BHL_IDX_VS_DONE)) begin
      readNext[BHL_FIELD_LSB +: VS_COUNT] = vsDone_q;
    end else if (bhl_hit(avsReq.address, BHL_IDX_VS_MASK)) begin
      readNext[BHL_FIELD_LSB +: VS_COUNT] = vsMask_q;                   // see (R7)
    end else if (bhl_hit(avsReq.address, BHL_IDX_VS_ACTIVE)) begin
      readNext[BHL_FIELD_LSB +: VS_COUNT] = vsSync2_q;                  // see (R8)
    end
  end

  // Read data is captured when the request is first seen and held through the answer.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      readData_q <= 32'h00000000;
    end else if (captureRd) begin
      readData_q <= readNext;
    end
  end

  // Clear masks. A read clears only the bits it actually returned, so an event that
  // lands between capture and the answer edge survives to the next read.
  always_comb begin
    hsClr = '0;
    vsClr = '0;
    if (acceptRd && bhl_hit(avsReq.address, BHL_IDX_HS_STATUS)) begin
      hsClr = readData_q[BHL_FIELD_LSB +: HS_COUNT];                    // see (R9)
    end else if (acceptWr && bhl_hit(avsReq.address, BHL_IDX_HS_STATUS)) begin
      hsClr = wrByte[BHL_FIELD_LSB +: HS_COUNT];                        // see (R9)
    end
    if (acceptRd && bhl_hit(avsReq.address, BHL_IDX_VS_DONE)) begin
      vsClr = readData_q[BHL_FIELD_LSB +: VS_COUNT];                    // see (R6)
    end else if (acceptWr && bhl_hit(avsReq.address, BHL_IDX_VS_DONE)) begin
      vsClr = wrByte[BHL_FIELD_LSB +: VS_COUNT];                        // see (R6)
    end
  end

  // Sticky flags: a new event in the clearing cycle wins over the clear.
  assign hsFlag_d = (hsFlag_q & ~hsClr) | hsRise;                       // see (R11)
  assign vsDone_d = (vsDone_q & ~vsClr) | vsFinish;                     // see (R5)

  // High-side limit flags.
  // A set and a clear in the same cycle leave the flag set, so no event is lost.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hsFlag_q <= {HS_COUNT{BHL_FLAG_RST_BIT}};
    end else begin
      hsFlag_q <= hsFlag_d;                                             // see (R11)
    end
  end

  // Voltage-scaling busy inputs pass two flops; the finish edge is taken after them.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      vsSync1_q <= '0;
      vsSync2_q <= '0;
      vsLast_q  <= '0;
    end else begin
      vsSync1_q <= vscaleBusyRaw;
      vsSync2_q <= vsSync1_q;
      vsLast_q  <= vsSync2_q;
    end
  end

  // Every finished transition counts, whether started by a register write or a state change.
  assign vsFinish = vsLast_q & ~vsSync2_q;                              // see (R5)

  // Voltage-scaling done flags, reset to zero.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      vsDone_q <= {VS_COUNT{BHL_FLAG_RST_BIT}};
    end else begin
      vsDone_q <= vsDone_d;                                             // see (R6)
    end
  end

  // Mask registers come up fully masked; only lane-0 writes to their own address land.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hsMask_q <= {HS_COUNT{BHL_MASK_RST_BIT}};
    end else if (acceptWr && bhl_hit(avsReq.address, BHL_IDX_HS_MASK)) begin
      hsMask_q <= wrByte[BHL_FIELD_LSB +: HS_COUNT];                    // see (R3)
    end
  end

  // Scaling-done masks; a write elsewhere or with lane 0 off leaves them alone.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      vsMask_q <= {VS_COUNT{BHL_MASK_RST_BIT}};
    end else if (acceptWr && bhl_hit(avsReq.address, BHL_IDX_VS_MASK)) begin
      vsMask_q <= wrByte[BHL_FIELD_LSB +: VS_COUNT];                    // see (R7)
    end
  end

  // A masked flag still records its event but never reaches the pin.
  assign pending = (|(hsFlag_q & ~hsMask_q)) | (|(vsDone_q & ~vsMask_q)); // see (R1)

  // The pin is registered so it never glitches while flags and masks change together.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irqN_q <= 1'b1;
    end else begin
      irqN_q <= ~pending;                                               // see (R2)
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  irq_pulled_low_a: assert property ( // see (R1)
    (|(hsFlag_q & ~hsMask_q) || |(vsDone_q & ~vsMask_q)) |=> !irqOutN
  ) else $error("Unmasked set flag did not pull the interrupt pin low.");

  irq_masked_high_a: assert property ( // see (R2)
    (((hsFlag_q & ~hsMask_q) == '0) && ((vsDone_q & ~vsMask_q) == '0)) |=> irqOutN
  ) else $error("Interrupt pin low with every set flag masked.");

  hs_mask_write_a: assert property ( // see (R3)
    (acceptWr && bhl_hit(avsReq.address, BHL_IDX_HS_MASK))
      |=> (hsMask_q == $past(wrByte[BHL_FIELD_LSB +: HS_COUNT]))
  ) else $error("High-side mask did not take the written value.");

  vs_done_set_a: assert property ( // see (R5)
    (vsLast_q[0] && !vsSync2_q[0]) |=> vsDone_q[0]
  ) else $error("Finished transition did not set the done flag.");

  vs_done_clear_a: assert property ( // see (R6)
    (acceptWr && bhl_hit(avsReq.address, BHL_IDX_VS_DONE) && wrByte[1] && !vsFinish[1])
      |=> !vsDone_q[1]
  ) else $error("Write of one did not clear the done flag.");

  vs_mask_write_a: assert property ( // see (R7)
    (acceptWr && bhl_hit(avsReq.address, BHL_IDX_VS_MASK))
      |=> (vsMask_q == $past(wrByte[BHL_FIELD_LSB +: VS_COUNT]))
  ) else $error("Scaling-done mask did not take the written value.");

  progress_read_a: assert property ( // see (R8)
    (busState_q == BHL_BUS_IDLE && avsReq.read
      && bhl_hit(avsReq.address, BHL_IDX_VS_ACTIVE))
      |=> (readData_q == {24'h000000, 8'(vsSync2_q)} || readData_q[7:0] == 8'($past(vsSync2_q)))
  ) else $error("Progress read did not return the busy bits.");

  hs_read_clear_a: assert property ( // see (R9)
    (acceptRd && bhl_hit(avsReq.address, BHL_IDX_HS_STATUS) && readData_q[1] && !hsRise[1])
      |=> !hsFlag_q[1]
  ) else $error("Read of high-side status did not clear the returned bit.");

  upper_bits_zero_a: assert property ( // see (R10)
    !waitReq_q |-> (readData_q[31:8] == 24'h000000)
  ) else $error("Unused upper read bits not zero.");

  hs_flag_set_a: assert property ( // see (R11)
    hsRise[1] |=> hsFlag_q[1]
  ) else $error("High-side flag not set by a sense rise.");

  // Read-back checks: each capture returns the register's own bits, upper bits zero.
  hs_status_read_a: assert property ( // see (R9)
    (captureRd && bhl_hit(avsReq.address, BHL_IDX_HS_STATUS))
      |=> (readData_q == {24'h000000, 8'($past(hsFlag_q))})
  ) else $error("High-side status read did not return the flags.");

  hs_mask_read_a: assert property ( // see (R3)
    (captureRd && bhl_hit(avsReq.address, BHL_IDX_HS_MASK))
      |=> (readData_q == {24'h000000, 8'($past(hsMask_q))})
  ) else $error("High-side mask read did not return the mask.");

  hs_sense_read_a: assert property ( // see (R4)
    (captureRd && bhl_hit(avsReq.address, BHL_IDX_HS_SENSE))
      |=> (readData_q == {24'h000000, 8'($past(hsSense))})
  ) else $error("High-side sense read did not return the held bits.");

  vs_done_read_a: assert property ( // see (R5)
    (captureRd && bhl_hit(avsReq.address, BHL_IDX_VS_DONE))
      |=> (readData_q == {24'h000000, 8'($past(vsDone_q))})
  ) else $error("Scaling-done read did not return the flags.");

  vs_mask_read_a: assert property ( // see (R7)
    (captureRd && bhl_hit(avsReq.address, BHL_IDX_VS_MASK))
      |=> (readData_q == {24'h000000, 8'($past(vsMask_q))})
  ) else $error("Scaling-done mask read did not return the mask.");

  unmapped_read_zero_a: assert property ( // see (R10)
    (captureRd && !bhl_hit(avsReq.address, BHL_IDX_HS_STATUS)
      && !bhl_hit(avsReq.address, BHL_IDX_HS_MASK) && !bhl_hit(avsReq.address, BHL_IDX_HS_SENSE)
      && !bhl_hit(avsReq.address, BHL_IDX_VS_DONE) && !bhl_hit(avsReq.address, BHL_IDX_VS_MASK)
      && !bhl_hit(avsReq.address, BHL_IDX_VS_ACTIVE))
      |=> (readData_q == 32'h00000000)
  ) else $error("Unmapped read did not return zero.");

  // Clear and hold checks: flags stay until cleared, and a clear never hides a new event.
  vs_read_clear_a: assert property ( // see (R6)
    (acceptRd && bhl_hit(avsReq.address, BHL_IDX_VS_DONE) && readData_q[0] && !vsFinish[0])
      |=> !vsDone_q[0]
  ) else $error("Read of scaling-done status did not clear the returned bit.");

  hs_write_clear_a: assert property ( // see (R9)
    (acceptWr && bhl_hit(avsReq.address, BHL_IDX_HS_STATUS) && wrByte[0] && !hsRise[0])
      |=> !hsFlag_q[0]
  ) else $error("Write of one did not clear the high-side flag.");

  hs_flag_hold_a: assert property ( // see (R11)
    (hsFlag_q[0] && !hsClr[0]) |=> hsFlag_q[0]
  ) else $error("High-side flag dropped without a clear.");

  vs_done_hold_a: assert property ( // see (R5)
    (vsDone_q[1] && !vsClr[1]) |=> vsDone_q[1]
  ) else $error("Scaling-done flag dropped without a clear.");

  vs_two_set_a: assert property ( // see (R5)
    vsFinish[1] |=> vsDone_q[1]
  ) else $error("Second converter finish did not set its done flag.");

  hs_rise_all_a: assert property ( // see (R11)
    (|hsRise) |=> ((hsFlag_q & $past(hsRise)) == $past(hsRise))
  ) else $error("A sense rise did not set its high-side flag.");

  lane_off_ignored_a: assert property ( // see (R10)
    ((busState_q == BHL_BUS_ACK) && avsReq.write && !avsReq.byteenable[0])
      |=> ($stable(hsMask_q) && $stable(vsMask_q))
  ) else $error("Write with lane 0 off changed a mask.");

  irq_release_a: assert property ( // see (R10)
    (!irqOutN && !pending) |=> irqOutN
  ) else $error("Interrupt pin stayed low after the last unmasked flag cleared.");

endmodule

// [bhl_pkg.sv]
// Shared constants, types and helpers for the buck limit and voltage-scaling interrupt block.
package bhl_pkg;

  // Clock and timing figures; the window count rounds down and never drops below one cycle.
  localparam int BHL_CLK_PERIOD_NS = 100;
  localparam int BHL_SW_PERIOD_NS  = 500;
  localparam int BHL_SW_PERIOD_CYC = (BHL_SW_PERIOD_NS / BHL_CLK_PERIOD_NS) < 1 ? 1 :
                                     (BHL_SW_PERIOD_NS / BHL_CLK_PERIOD_NS);

  // Converter counts as documented.
  localparam int BHL_HS_COUNT = 3;
  localparam int BHL_VS_COUNT = 2;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] BHL_IDX_HS_STATUS = 8'h0B;
  localparam logic [7:0] BHL_IDX_HS_MASK   = 8'h0C;
  localparam logic [7:0] BHL_IDX_HS_SENSE  = 8'h0D;
  localparam logic [7:0] BHL_IDX_VS_DONE   = 8'h0E;
  localparam logic [7:0] BHL_IDX_VS_MASK   = 8'h0F;
  localparam logic [7:0] BHL_IDX_VS_ACTIVE = 8'h10;

  // Field positions: every field starts at bit 0 of its register.
  localparam int BHL_FIELD_LSB = 0;

  // Reset values.
  localparam logic       BHL_MASK_RST_BIT = 1'b1;
  localparam logic       BHL_FLAG_RST_BIT = 1'b0;
  localparam logic [7:0] BHL_READ_ZERO    = 8'h00;

  // Register bus request as driven by the Avalon-MM master.
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } bhl_avs_req_t;

  // Bus handshake states.
  typedef enum logic [0:0] {
    BHL_BUS_IDLE = 1'b0,
    BHL_BUS_ACK  = 1'b1
  } bhl_bus_state_t;

  // True when a byte address selects the register with the given index.
  function automatic logic bhl_hit(input logic [7:0] addr, input logic [7:0] idx);
    return addr == {idx[5:0], 2'b00};
  endfunction

endpackage

// [bhl_sense_hold.sv]
// Synchroniser and switching-cycle hold for the high-side current-limit sense bits.
`timescale 1ns/1ps
module bhl_sense_hold #(
  parameter int WIDTH      = bhl_pkg::BHL_HS_COUNT,
  parameter int PERIOD_CYC = bhl_pkg::BHL_SW_PERIOD_CYC
) (
  input  wire logic             mclk,      // System clock.
  input  wire logic             nrst,      // Asynchronous reset, active low.
  input  wire logic [WIDTH-1:0] faultRaw,  // Comparator outputs from the power stage.
  output logic      [WIDTH-1:0] sense,     // Held fault state, one bit per converter.
  output logic      [WIDTH-1:0] senseRise  // One-cycle pulse when a held bit rises.
);
  import bhl_pkg::*;

  // Refuse sizes the window counter cannot serve.
  if (WIDTH < 1 || WIDTH > 8 || PERIOD_CYC < 1 || PERIOD_CYC > 65535) begin : g_chk
    $error("bhl_sense_hold: WIDTH or PERIOD_CYC out of range.");
  end

  logic [WIDTH-1:0] sync1_q;
  logic [WIDTH-1:0] sync2_q;
  logic [WIDTH-1:0] accum_q;
  logic [WIDTH-1:0] sense_q;
  logic [WIDTH-1:0] rise_q;
  logic [15:0]      winCnt_q;
  logic             winEnd;
  logic [WIDTH-1:0] seen;

  assign winEnd    = (winCnt_q == 16'(PERIOD_CYC - 1));
  assign seen      = accum_q | sync2_q;
  assign sense     = sense_q;
  assign senseRise = rise_q;

  // Two-flop synchroniser; the first stage feeds only the second.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= faultRaw;
      sync2_q <= sync1_q;
    end
  end

  // Free-running window that stands for one buck switching cycle.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      winCnt_q <= '0;
    end else if (winEnd) begin
      winCnt_q <= '0;
    end else begin
      winCnt_q <= winCnt_q + 16'h0001;
    end
  end

  // Any fault seen within a window is reported for the whole next window, so the bit
  // cannot chatter at the switching rate; the cost is up to one window of latency.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      accum_q <= '0;
      sense_q <= '0;
      rise_q  <= '0;
    end else if (winEnd) begin
      accum_q <= '0;
      sense_q <= seen;              // see (R4)
      rise_q  <= seen & ~sense_q;
    end else begin
      accum_q <= seen;
      rise_q  <= '0;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  sense_held_stable_a: assert property ( // see (R4)
    !winEnd |=> $stable(sense_q)
  ) else $error("Sense bit changed inside a switching window.");

endmodule

// [bhl_stage_model.sv]
// Far-side model: power stage comparators and the host's interrupt input.
`timescale 1ns/1ps
module bhl_stage_model (
  input  wire logic       mclk,          // System clock.
  input  wire logic       nrst,          // Reset, active low.
  input  wire logic [2:0] faultSet,      // Wanted high-side fault levels.
  input  wire logic [1:0] busySet,       // Wanted transition-in-progress levels.
  input  wire logic       irqOutN,       // Interrupt pin as the host sees it.
  output logic      [2:0] hilimFaultRaw, // Comparator outputs.
  output logic      [1:0] vscaleBusyRaw, // Transition busy outputs.
  output logic      [7:0] irqFalls       // Count of interrupt assertions.
);
  logic irqPrev;

  // Levels follow the commands one edge late, as a real stage lags its control.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hilimFaultRaw <= 3'h0;
      vscaleBusyRaw <= 2'h0;
    end else begin
      hilimFaultRaw <= faultSet;
      vscaleBusyRaw <= busySet;
    end
  end

  // Counting falls lets the bench tell separate assertions from a stuck pin.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irqPrev  <= 1'b1;
      irqFalls <= 8'h00;
    end else begin
      irqPrev <= irqOutN;
      if (irqPrev && !irqOutN) begin
        irqFalls <= irqFalls + 8'h01;
      end
    end
  end
endmodule

// [bhl_irq_regs_bench.sv]
// Self-checking bench for the buck limit and voltage-scaling interrupt registers.
`timescale 1ns/1ps
module bhl_irq_regs_bench;
  import bhl_pkg::*;
  localparam int PCYC = 2;
  logic              mclk;
  logic              nrst;
  logic              irqOutN;
  logic              avsWaitRequest;
  logic [31:0]       avsReadData;
  bhl_avs_req_t      avsReq;
  logic [2:0]        faultSet;
  logic [2:0]        hilimFaultRaw;
  logic [1:0]        busySet;
  logic [1:0]        vscaleBusyRaw;
  logic [7:0]        irqFalls;
  logic [3:0]        benable;
  int                miscompares;
  int                compares;

  // A short switching window keeps the sense latency to a few cycles.
  bhl_irq_regs #(.PERIOD_CYC(PCYC)) u_bhl_irq_regs (
    .mclk(mclk), .nrst(nrst), .avsReq(avsReq), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .hilimFaultRaw(hilimFaultRaw),
    .vscaleBusyRaw(vscaleBusyRaw), .irqOutN(irqOutN));

  bhl_stage_model u_bhl_stage_model (
    .mclk(mclk), .nrst(nrst), .faultSet(faultSet), .busySet(busySet), .irqOutN(irqOutN),
    .hilimFaultRaw(hilimFaultRaw), .vscaleBusyRaw(vscaleBusyRaw), .irqFalls(irqFalls));

  // 10 MHz clock.
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access: hold the request until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avsReq <= '{address: a, read: !wr, write: wr, writedata: {24'h00_0000, d},
                byteenable: benable};
    do begin
      @(posedge mclk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    q = avsReadData;
    avsReq <= '{default: '0};
    if (avsWaitRequest !== 1'b0) begin
      miscompares++;
      $display("Error at %0t: bus wait timed out", $time);
      give_verdict();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h00_0000, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic irq(input logic e);
    chk({31'h0000_0000, irqOutN}, {31'h0000_0000, e});
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge mclk);
  endtask

  // A hang anywhere counts as a mismatch and ends the run.
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    $display("Error at %0t: run timed out", $time);
    give_verdict();
  end

  // Main sequence.
  initial begin
    nrst = 1'b0;
    avsReq = '{default: '0};
    benable = 4'hF;
    faultSet = 3'h0;
    busySet = 2'h0;
    miscompares = 0;
    compares = 0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    rd(8'h30, 8'h07);
    rd(8'h3C, 8'h03);
    rd(8'h2C, 8'h00);
    rd(8'h38, 8'h00);
    rd(8'h34, 8'h00);
    rd(8'h40, 8'h00);
    rd(8'h44, 8'h00);
    wr(8'h30, 8'hFE);
    rd(8'h30, 8'h06);
    // A write with byte lane 0 off must leave the mask alone.
    benable = 4'hE;
    wr(8'h30, 8'h01);
    benable = 4'hF;
    rd(8'h30, 8'h06);
    irq(1'b1);
    $display("test reset_and_masks done");
    // Converter two faults while masked: flag records, pin stays high.
    faultSet <= 3'h2;
    wt(4 * PCYC + 6);
    rd(8'h34, 8'h02);
    irq(1'b1);
    rd(8'h2C, 8'h02);
    rd(8'h2C, 8'h00);
    $display("test masked_limit done");
    // Converter one faults unmasked, then write-one clears it.
    faultSet <= 3'h1;
    wt(4 * PCYC + 6);
    rd(8'h34, 8'h01);
    irq(1'b0);
    wr(8'h2C, 8'h01);
    wt(2);
    irq(1'b1);
    rd(8'h2C, 8'h00);
    faultSet <= 3'h0;
    wt(4 * PCYC + 6);
    rd(8'h34, 8'h00);
    $display("test unmasked_limit done");
    // Converter one scaling completes unmasked; a read clears the flag.
    wr(8'h3C, 8'h02);
    busySet <= 2'h1;
    wt(4);
    rd(8'h40, 8'h01);
    busySet <= 2'h0;
    wt(6);
    irq(1'b0);
    rd(8'h38, 8'h01);
    rd(8'h38, 8'h00);
    wt(2);
    irq(1'b1);
    $display("test scaling_read_clear done");
    // Converter two completes masked, is unmasked later, then cleared by write-one.
    busySet <= 2'h2;
    wt(4);
    rd(8'h40, 8'h02);
    busySet <= 2'h0;
    wt(6);
    irq(1'b1);
    wr(8'h3C, 8'h00);
    wt(2);
    irq(1'b0);
    wr(8'h38, 8'h02);
    wt(2);
    irq(1'b1);
    rd(8'h38, 8'h00);
    chk({24'h00_0000, irqFalls}, 32'h0000_0003);
    $display("test scaling_write_clear done");
    // A mid-run reset with an unmasked flag set brings back the reset state.
    faultSet <= 3'h1;
    wt(4 * PCYC + 6);
    irq(1'b0);
    faultSet <= 3'h0;
    nrst <= 1'b0;
    wt(3);
    irq(1'b1);
    nrst <= 1'b1;
    rd(8'h30, 8'h07);
    rd(8'h3C, 8'h03);
    rd(8'h2C, 8'h00);
    rd(8'h34, 8'h00);
    $display("test midrun_reset done");
    give_verdict();
  end
endmodule
